// ===== rtl/nvmri_pkg.sv
// Package for the flash reset initialisation sequencer and address map
package nvmri_pkg;

    // ----------------------------------------
    // Register offsets (byte index on the register port)
    // ----------------------------------------
    localparam logic [3:0] NVMRI_ADDR_STATUS = 4'h0;
    localparam logic [3:0] NVMRI_ADDR_FLASH_PROT = 4'h1;
    localparam logic [3:0] NVMRI_ADDR_EE_PROT = 4'h2;
    localparam logic [3:0] NVMRI_ADDR_OPTION = 4'h3;
    localparam logic [3:0] NVMRI_ADDR_SECURITY = 4'h4;
    localparam logic [3:0] NVMRI_ADDR_CONFIG = 4'h5;
    localparam logic [3:0] NVMRI_ADDR_COMMAND = 4'h6;
    localparam logic [3:0] NVMRI_ADDR_IRQ_STAT = 4'h7;
    localparam logic [3:0] NVMRI_ADDR_IRQ_MASK = 4'h8;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int NVMRI_BIT_DONE_FLAG = 7;
    localparam int NVMRI_BIT_VFLT_HI = 1;
    localparam int NVMRI_BIT_VFLT_LO = 0;
    localparam int NVMRI_BIT_IRQ_DONE = 0;
    localparam int NVMRI_BIT_IRQ_DBL = 1;
    localparam int NVMRI_BIT_IRQ_ABORT = 2;
    localparam int NVMRI_BIT_IRQ_REJ = 3;

    // ----------------------------------------
    // Built-in fallback values: fully protected and secured
    // ----------------------------------------
    localparam logic [7:0] NVMRI_DEF_FLASH_PROT = 8'h00;
    localparam logic [7:0] NVMRI_DEF_EE_PROT = 8'h00;
    localparam logic [7:0] NVMRI_DEF_OPTION = 8'h00;
    localparam logic [7:0] NVMRI_DEF_SECURITY = 8'h00;
    localparam logic [7:0] NVMRI_DEF_CONFIG = 8'h00;
    localparam logic [7:0] NVMRI_RST_BYTE = 8'h00;

    // ----------------------------------------
    // Load sequence and counts
    // ----------------------------------------
    localparam logic [2:0] NVMRI_LOAD_WORDS = 3'h5;
    localparam logic [2:0] NVMRI_HOLD_WORDS = 3'h2;

    // ----------------------------------------
    // Flash map
    // ----------------------------------------
    localparam int NVMRI_SECTOR_BYTES = 512;
    localparam int NVMRI_SECT_BITS = 7;
    localparam logic [6:0] NVMRI_SECT_LAST_NA = 7'h07;
    localparam logic [6:0] NVMRI_SECT_PART = 7'h08;
    localparam logic [6:0] NVMRI_SECT_HOLE = 7'h18;
    localparam logic [8:0] NVMRI_PART_FIRST_OFS = 9'h040;
    localparam logic [15:0] NVMRI_SMALL_BASE = 16'h8000;

    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    typedef enum logic [2:0] {
        NVMRI_ST_HOLD = 3'b000,
        NVMRI_ST_LOAD = 3'b001,
        NVMRI_ST_DONE = 3'b010,
        NVMRI_ST_BUSY = 3'b011
    } nvmri_state_t;

endpackage

// ===== rtl/nvmri_top.sv
// Flash and EEPROM reset initialisation sequencer with flash address map
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
// Summary of operation
// - Every reset runs a sequence loading config, both protections, option and security bytes.
// - Any load error makes all loaded values fall back to fully protected and secured defaults.
// - A double-bit fault during the sequence sets both verify fault status bits.
// - The command complete flag stays low for the whole sequence.
// - The flag goes high when the sequence ends, which lets user commands in.
// - CPU access is stalled early in the sequence and array reads are served after that.
// - A reset only clears a pending launch pulse; nothing tells the command engine to abort a program or erase.
// - Large size: flash is decoded across the full 16-bit range 0x0000 to 0xffff.
// - Flash under RAM, EEPROM or register windows is not reachable; the other resource wins.
// - The large size has 128 sectors of 512 bytes.
// - Large size: sectors 0 to 7 and 24 are unusable, sector 8 only its last 448 bytes.
// - The small size has 64 sectors of 512 bytes, all usable.
// - The small size sits from 0x8000 upward as sectors 64 to 127.
module nvmri_top
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Configuration: 1 selects the 64 KB array
    input wire logic large_array,
    // Nonvolatile fetch port
    output logic nv_req,
    output logic [2:0] nv_index,
    input wire logic nv_valid,
    input wire logic [7:0] nv_data,
    input wire logic nv_error,
    input wire logic nv_dbl_fault,
    // Command engine
    output logic cmd_launch,
    input wire logic cmd_active,
    // CPU memory bus decode
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_req,
    input wire logic other_hit,
    output logic cpu_stall,
    output logic flash_sel,
    output logic [6:0] flash_sector,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Interrupt
    output logic irq
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    nvmri_pkg::nvmri_state_t state_reg, state_next;
    logic [2:0] idx_reg, idx_next;
    logic err_reg, err_next;
    logic [7:0] flash_protection_reg, flash_protection_next;
    logic [7:0] eeprom_protection_reg, eeprom_protection_next;
    logic [7:0] nonvolatile_option_reg, nonvolatile_option_next;
    logic [7:0] security_setting_reg, security_setting_next;
    logic [7:0] cfg_reg, cfg_next;
    logic command_complete_flag_reg, command_complete_flag_next;
    logic [1:0] vflt_reg, vflt_next;
    logic req_reg, req_next;
    logic stall_reg, stall_next;
    logic launch_reg, launch_next;
    logic sel_reg, sel_next;
    logic [6:0] sect_reg, sect_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [3:0] ist_reg, ist_next;
    logic [3:0] imask_reg, imask_next;
    logic irq_reg, irq_next;

    logic [6:0] sect;
    logic [8:0] sofs;
    logic usable;
    logic [3:0] ev;
    logic cmd_wr;

    // ----------------------------------------
    // Flash map
    // ----------------------------------------
    always_comb
    begin
        sect = cpu_addr[15:9];
        sofs = cpu_addr[8:0];
        if (large_array)
        begin
            if (sect <= nvmri_pkg::NVMRI_SECT_LAST_NA || sect == nvmri_pkg::NVMRI_SECT_HOLE)
                usable = 1'b0;
            else if (sect == nvmri_pkg::NVMRI_SECT_PART)
                usable = sofs >= nvmri_pkg::NVMRI_PART_FIRST_OFS;
            else
                usable = 1'b1;
        end
        else
        begin
            usable = cpu_addr >= nvmri_pkg::NVMRI_SMALL_BASE;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        state_next = state_reg;
        idx_next = idx_reg;
        err_next = err_reg;
        flash_protection_next = flash_protection_reg;
        eeprom_protection_next = eeprom_protection_reg;
        nonvolatile_option_next = nonvolatile_option_reg;
        security_setting_next = security_setting_reg;
        cfg_next = cfg_reg;
        command_complete_flag_next = command_complete_flag_reg;
        vflt_next = vflt_reg;
        req_next = 1'b0;
        launch_next = 1'b0;
        rdata_next = nvmri_pkg::NVMRI_RST_BYTE;
        imask_next = imask_reg;
        ev = 4'h0;
        cmd_wr = reg_wr && reg_addr == nvmri_pkg::NVMRI_ADDR_COMMAND;
        // Stall lags the load index by one cycle
        stall_next = (state_reg == nvmri_pkg::NVMRI_ST_HOLD)
            || (state_reg == nvmri_pkg::NVMRI_ST_LOAD && idx_reg < nvmri_pkg::NVMRI_HOLD_WORDS);
        sel_next = cpu_req && usable && !other_hit && !stall_next;
        sect_next = sect;
        case (state_reg)
            nvmri_pkg::NVMRI_ST_HOLD:
            begin
                command_complete_flag_next = 1'b0;
                state_next = nvmri_pkg::NVMRI_ST_LOAD;
                idx_next = 3'h0;
                req_next = 1'b1;
            end
            nvmri_pkg::NVMRI_ST_LOAD:
            begin
                req_next = !nv_valid;
                // Word taken in the cycle it is valid
                if (nv_valid)
                begin
                    if (nv_dbl_fault)
                    begin
                        vflt_next = 2'b11;
                        ev[nvmri_pkg::NVMRI_BIT_IRQ_DBL] = 1'b1;
                    end
                    if (nv_error || nv_dbl_fault)
                        err_next = 1'b1;
                    case (idx_reg)
                        3'h0: cfg_next = nv_data;
                        3'h1: flash_protection_next = nv_data;
                        3'h2: eeprom_protection_next = nv_data;
                        3'h3: nonvolatile_option_next = nv_data;
                        default: security_setting_next = nv_data;
                    endcase
                    idx_next = 3'(idx_reg + 3'h1);
                    req_next = 1'b1;
                    if (idx_reg == 3'(nvmri_pkg::NVMRI_LOAD_WORDS - 3'h1))
                    begin
                        req_next = 1'b0;
                        state_next = nvmri_pkg::NVMRI_ST_DONE;
                        command_complete_flag_next = 1'b1;
                        ev[nvmri_pkg::NVMRI_BIT_IRQ_DONE] = 1'b1;
                        if (err_reg || nv_error || nv_dbl_fault)
                        begin
                            cfg_next = nvmri_pkg::NVMRI_DEF_CONFIG;
                            flash_protection_next = nvmri_pkg::NVMRI_DEF_FLASH_PROT;
                            eeprom_protection_next = nvmri_pkg::NVMRI_DEF_EE_PROT;
                            nonvolatile_option_next = nvmri_pkg::NVMRI_DEF_OPTION;
                            security_setting_next = nvmri_pkg::NVMRI_DEF_SECURITY;
                        end
                    end
                end
                if (cmd_wr)
                    ev[nvmri_pkg::NVMRI_BIT_IRQ_REJ] = 1'b1;
            end
            nvmri_pkg::NVMRI_ST_DONE:
            begin
                // Launch accepted only with the flag high
                if (cmd_wr)
                begin
                    launch_next = 1'b1;
                    command_complete_flag_next = 1'b0;
                    state_next = nvmri_pkg::NVMRI_ST_BUSY;
                end
            end
            nvmri_pkg::NVMRI_ST_BUSY:
            begin
                // Flag low: further launches refused
                if (cmd_wr)
                    ev[nvmri_pkg::NVMRI_BIT_IRQ_REJ] = 1'b1;
                // Engine idle again: flag returns
                if (!cmd_active && !launch_reg)
                begin
                    command_complete_flag_next = 1'b1;
                    state_next = nvmri_pkg::NVMRI_ST_DONE;
                end
            end
            default:
            begin
                state_next = nvmri_pkg::NVMRI_ST_HOLD;
            end
        endcase
        if (reg_wr && reg_addr == nvmri_pkg::NVMRI_ADDR_IRQ_MASK)
            imask_next = reg_wdata[3:0];
        if (reg_rd)
        begin
            if (reg_addr == nvmri_pkg::NVMRI_ADDR_STATUS)
                rdata_next = {command_complete_flag_reg, 5'h00, vflt_reg};
            else if (reg_addr == nvmri_pkg::NVMRI_ADDR_FLASH_PROT)
                rdata_next = flash_protection_reg;
            else if (reg_addr == nvmri_pkg::NVMRI_ADDR_EE_PROT)
                rdata_next = eeprom_protection_reg;
            else if (reg_addr == nvmri_pkg::NVMRI_ADDR_OPTION)
                rdata_next = nonvolatile_option_reg;
            else if (reg_addr == nvmri_pkg::NVMRI_ADDR_SECURITY)
                rdata_next = security_setting_reg;
            else if (reg_addr == nvmri_pkg::NVMRI_ADDR_CONFIG)
                rdata_next = cfg_reg;
            else if (reg_addr == nvmri_pkg::NVMRI_ADDR_IRQ_STAT)
                rdata_next = {4'h0, ist_reg};
            else if (reg_addr == nvmri_pkg::NVMRI_ADDR_IRQ_MASK)
                rdata_next = {4'h0, imask_reg};
            else
                rdata_next = nvmri_pkg::NVMRI_RST_BYTE;
        end
        // Read clears, a new event in the same cycle wins
        if (reg_rd && reg_addr == nvmri_pkg::NVMRI_ADDR_IRQ_STAT)
            ist_next = ev;
        else
            ist_next = ist_reg | ev;
        irq_next = |(ist_next & imask_next);
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            // Reset clears the launch pulse and restarts the state; a command already running in the engine is not stopped
            state_reg <= nvmri_pkg::NVMRI_ST_HOLD;
            idx_reg <= 3'h0;
            err_reg <= 1'b0;
            // Fallback values until each word of the load is taken
            flash_protection_reg <= nvmri_pkg::NVMRI_DEF_FLASH_PROT;
            eeprom_protection_reg <= nvmri_pkg::NVMRI_DEF_EE_PROT;
            nonvolatile_option_reg <= nvmri_pkg::NVMRI_DEF_OPTION;
            security_setting_reg <= nvmri_pkg::NVMRI_DEF_SECURITY;
            cfg_reg <= nvmri_pkg::NVMRI_DEF_CONFIG;
            command_complete_flag_reg <= 1'b0;
            vflt_reg <= 2'b00;
            req_reg <= 1'b0;
            stall_reg <= 1'b1;
            launch_reg <= 1'b0;
            sel_reg <= 1'b0;
            sect_reg <= 7'h00;
            rdata_reg <= nvmri_pkg::NVMRI_RST_BYTE;
            ist_reg <= 4'h0;
            imask_reg <= 4'h0;
            irq_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            idx_reg <= idx_next;
            err_reg <= err_next;
            flash_protection_reg <= flash_protection_next;
            eeprom_protection_reg <= eeprom_protection_next;
            nonvolatile_option_reg <= nonvolatile_option_next;
            security_setting_reg <= security_setting_next;
            cfg_reg <= cfg_next;
            command_complete_flag_reg <= command_complete_flag_next;
            vflt_reg <= vflt_next;
            req_reg <= req_next;
            stall_reg <= stall_next;
            launch_reg <= launch_next;
            sel_reg <= sel_next;
            sect_reg <= sect_next;
            rdata_reg <= rdata_next;
            ist_reg <= ist_next;
            imask_reg <= imask_next;
            irq_reg <= irq_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------

    assign nv_req = req_reg;
    assign nv_index = idx_reg;
    assign cmd_launch = launch_reg;
    assign cpu_stall = stall_reg;
    assign flash_sel = sel_reg;
    assign flash_sector = sect_reg;
    assign reg_rdata = rdata_reg;
    assign irq = irq_reg;

endmodule

// ===== tb/nvmri_properties.sv
// Concurrent checks on the sequencer and flash map ports
`timescale 1ns/10ps
module nvmri_properties
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Observed ports
    input wire logic large_array,
    input wire logic nv_req,
    input wire logic [2:0] nv_index,
    input wire logic nv_valid,
    input wire logic cmd_launch,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_req,
    input wire logic other_hit,
    input wire logic cpu_stall,
    input wire logic flash_sel,
    input wire logic [6:0] flash_sector
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic upper_due;
    // Upper half access that must reach flash
    always_ff @(posedge ref_clk)
    begin
        upper_due <= rstn && cpu_req && !other_hit && !cpu_stall && cpu_addr[15];
    end
    a_load_step: assert property (nv_req && nv_valid |=> !nv_req || nv_index == $past(nv_index) + 3'h1)
        else $error("load index did not step");
    a_load_end: assert property ($fell(nv_req) |-> $past(nv_index) == 3'h4 && $past(nv_valid))
        else $error("load ended early");
    a_no_launch_load: assert property (nv_req |-> !cmd_launch)
        else $error("launch during load");
    a_stall_span: assert property (cpu_stall && $past(rstn) |-> nv_req && $past(nv_index) < 3'h2)
        else $error("stall outside early load");
    a_stall_lift: assert property (!cpu_stall && nv_req |-> nv_index >= 3'h2)
        else $error("stall lifted too soon");
    a_sel_cause: assert property (flash_sel |-> $past(cpu_req) && !$past(other_hit) && !cpu_stall)
        else $error("flash selected without cause");
    a_sel_sector: assert property (flash_sel |-> flash_sector == $past(cpu_addr[15:9]))
        else $error("wrong sector");
    a_small_upper: assert property (flash_sel && !large_array |-> flash_sector >= 7'h40)
        else $error("small map hit below upper half");
    a_large_holes: assert property (flash_sel && large_array |-> (flash_sector > 7'h08 && flash_sector != 7'h18)
        || (flash_sector == 7'h08 && $past(cpu_addr[8:0]) >= 9'h040))
        else $error("large map hit in reserved sector");
    a_upper_usable: assert property (upper_due |-> flash_sel)
        else $error("usable flash not selected");
    a_launch_once: assert property (cmd_launch |=> !cmd_launch)
        else $error("launch longer than one cycle");
endmodule
bind nvmri_top nvmri_properties chk_u (.ref_clk(ref_clk), .rstn(rstn), .large_array(large_array),
    .nv_req(nv_req), .nv_index(nv_index), .nv_valid(nv_valid), .cmd_launch(cmd_launch), .cpu_addr(cpu_addr),
    .cpu_req(cpu_req), .other_hit(other_hit), .cpu_stall(cpu_stall), .flash_sel(flash_sel),
    .flash_sector(flash_sector));

// ===== tb/nvmri_nv_model.sv
// Nonvolatile storage model answering the fetch port
`timescale 1ns/10ps
module nvmri_nv_model
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Behaviour controls
    input wire logic [3:0] delay,
    input wire logic [2:0] err_idx,
    input wire logic [2:0] dbl_idx,
    // Fetch port
    input wire logic nv_req,
    input wire logic [2:0] nv_index,
    output logic nv_valid,
    output logic [7:0] nv_data,
    output logic nv_error,
    output logic nv_dbl_fault
);
    logic [3:0] wait_cnt;
    logic [7:0] word;
    assign word = 8'ha0 + {5'h00, nv_index};
    // Data only good in the valid cycle
    assign nv_data = nv_valid ? word : ~word;
    assign nv_error = nv_valid && nv_index == err_idx;
    assign nv_dbl_fault = nv_valid && nv_index == dbl_idx;
    always_ff @(posedge ref_clk)
    begin
        nv_valid <= rstn && nv_req && !nv_valid && wait_cnt >= delay;
        wait_cnt <= (!rstn || nv_valid || !nv_req) ? 4'h0 : wait_cnt + 4'h1;
    end
endmodule

// ===== tb/nvmri_bench.sv
// Self-checking bench for the sequencer and flash map
`timescale 1ns/10ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module nvmri_bench;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic large_array = 1'b1;
    logic cmd_active = 1'b0;
    logic cpu_req = 1'b0;
    logic other_hit = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] cpu_addr = 16'h0000;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [3:0] delay = 4'h2;
    logic [2:0] err_idx = 3'h7;
    logic [2:0] dbl_idx = 3'h7;
    logic nv_req, nv_valid, nv_error, nv_dbl_fault, cmd_launch, cpu_stall, flash_sel, irq;
    logic [2:0] nv_index;
    logic [7:0] nv_data, reg_rdata;
    logic [6:0] flash_sector;
    int n_errors = 0;
    int n_tests = 0;
    always #25 ref_clk = ~ref_clk;
    nvmri_top dut_u (.ref_clk(ref_clk), .rstn(rstn), .large_array(large_array), .nv_req(nv_req),
        .nv_index(nv_index), .nv_valid(nv_valid), .nv_data(nv_data), .nv_error(nv_error),
        .nv_dbl_fault(nv_dbl_fault), .cmd_launch(cmd_launch), .cmd_active(cmd_active), .cpu_addr(cpu_addr),
        .cpu_req(cpu_req), .other_hit(other_hit), .cpu_stall(cpu_stall), .flash_sel(flash_sel),
        .flash_sector(flash_sector), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    nvmri_nv_model nv_u (.ref_clk(ref_clk), .rstn(rstn), .delay(delay), .err_idx(err_idx),
        .dbl_idx(dbl_idx), .nv_req(nv_req), .nv_index(nv_index), .nv_valid(nv_valid), .nv_data(nv_data),
        .nv_error(nv_error), .nv_dbl_fault(nv_dbl_fault));
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        `CHK(reg_rdata, exp)
    endtask
    task automatic t_boot(input logic big, input logic [3:0] dl, input logic [2:0] ei, input logic [2:0] di);
        logic [7:0] fb;
        int i;
        @(posedge ref_clk);
        rstn <= 1'b0;
        large_array <= big;
        delay <= dl;
        err_idx <= ei;
        dbl_idx <= di;
        cpu_req <= 1'b1;
        cpu_addr <= 16'hc000;
        repeat (8) @(posedge ref_clk);
        `CHK(cmd_launch, 1'b0)
        rstn <= 1'b1;
        chk_rd(4'h0, 8'h00);
        wr(4'h6, 8'h5a);
        i = 0;
        @(negedge ref_clk);
        while (cpu_stall === 1'b1 && i < 200) begin @(negedge ref_clk); i++; end
        @(negedge ref_clk);
        `CHK(flash_sel, 1'b1)
        i = 0;
        while (nv_req === 1'b1 && i < 200) begin @(negedge ref_clk); i++; end
        fb = (ei != 3'h7 || di != 3'h7) ? nvmri_pkg::NVMRI_DEF_FLASH_PROT : 8'ha0;
        chk_rd(4'h0, (di != 3'h7) ? 8'h83 : 8'h80);
        for (i = 1; i < 6; i++) chk_rd(i[3:0], (fb == 8'h00) ? 8'h00 : 8'ha0 + 8'(i % 5));
        chk_rd(4'h7, (di != 3'h7) ? 8'h0b : 8'h09);
        chk_rd(4'h7, 8'h00);
        wr(4'h1, 8'hff);
        chk_rd(4'h1, fb + 8'(fb != 8'h00));
        chk_rd(4'hf, 8'h00);
        $display("boot test done");
    endtask
    task automatic t_map();
        logic [15:0] adr [10] = '{16'h0000, 16'h0fff, 16'h103f, 16'h1040, 16'h2000, 16'h3000, 16'h31ff,
            16'h3200, 16'h7fff, 16'h8000};
        logic [9:0] lg = 10'b1110011000;
        int i;
        for (i = 0; i < 11; i++)
        begin
            @(posedge ref_clk);
            cpu_addr <= (i < 10) ? adr[i] : 16'hffff;
            @(posedge ref_clk);
            @(negedge ref_clk);
            if (i < 10) `CHK(flash_sel, large_array ? lg[i] : adr[i][15])
        end
        `CHK(flash_sector, 7'h7f)
        @(posedge ref_clk);
        other_hit <= 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK(flash_sel, 1'b0)
        @(posedge ref_clk);
        other_hit <= 1'b0;
        $display("map test done");
    endtask
    task automatic t_cmd();
        int i;
        cmd_active <= 1'b1;
        wr(4'h8, 8'h00);
        wr(4'h6, 8'h01);
        i = 0;
        while (cmd_launch !== 1'b1 && i < 4) begin @(negedge ref_clk); i++; end
        `CHK(cmd_launch, 1'b1)
        chk_rd(4'h0, 8'h00);
        wr(4'h6, 8'h01);
        repeat (2) @(negedge ref_clk);
        `CHK(irq, 1'b0)
        wr(4'h8, 8'h08);
        repeat (2) @(negedge ref_clk);
        `CHK(irq, 1'b1)
        chk_rd(4'h7, 8'h08);
        repeat (2) @(negedge ref_clk);
        `CHK(irq, 1'b0)
        @(posedge ref_clk);
        cmd_active <= 1'b0;
        repeat (4) @(negedge ref_clk);
        chk_rd(4'h0, 8'h80);
        @(posedge ref_clk);
        cmd_active <= 1'b1;
        wr(4'h6, 8'h02);
        $display("command test done");
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        t_boot(1'b1, 4'h3, 3'h7, 3'h7);
        t_map();
        t_cmd();
        t_boot(1'b1, 4'h2, 3'h2, 3'h7);
        t_boot(1'b0, 4'h5, 3'h7, 3'h4);
        t_map();
        end_of_test();
    end
    initial
    begin
        #2000000;
        n_errors++;
        end_of_test();
    end
endmodule
